// ==== rtl/mrx_alu.v ====
/*
 Result and zero-flag update-enable generator for the execution core.
 Assumes operands are registered by the caller; purely combinational.
*/
`timescale 1ns/1ps
`include "mrx_defs.vh"

module mrx_alu (
   // Operation and operands
   input  wire [2:0] i_op,
   input  wire [7:0] i_w,
   input  wire [7:0] i_file,
   input  wire [7:0] i_literal,
   // Result and zero-flag update enable
   output reg  [7:0] o_result,
   output reg        o_zero_upd
);

   ////////////////////////////////////////////////////////////////////////
   // Result mux; zero update only for OR and copy
   always @* begin
      o_result   = i_w;
      o_zero_upd = 1'b0;
      case (i_op)
         `MRX_OP_OR_W_FILE: begin
            o_result   = i_w | i_file;
            o_zero_upd = 1'b1;
         end
         `MRX_OP_COPY_FILE: begin
            o_result   = i_file;
            o_zero_upd = 1'b1;
         end
         `MRX_OP_STORE_W: begin
            o_result   = i_w;
         end
         `MRX_OP_LOAD_LIT: begin
            o_result   = i_literal;
         end
         default: begin
            o_result   = i_w;
            o_zero_upd = 1'b0;
         end
      endcase
   end

endmodule // mrx_alu

// ==== rtl/mrx_core.v ====
/*
 Execution core for OR, move, load, idle and interrupt-return.
 Holds the working register, the zero flag, the interrupt control
 register, the program counter image and the 128-word file register
 array, and sequences the two-cycle interrupt return.
 Assumes the fetch stage presents one instruction with i_valid for one
 cycle while o_ready is high; the caller owns the stack contents and
 pops when o_stack_pop pulses. All inputs come from logic on i_clock,
 so none of them is synchronised here.
*/
`timescale 1ns/1ps
`include "mrx_defs.vh"

module mrx_core (
   // Clock and reset
   input  wire                         i_clock,
   input  wire                         i_reset_n,
   // Instruction in
   input  wire                         i_valid,
   input  wire [2:0]                   i_op,
   input  wire [`MRX_ADDR_W-1:0]       i_addr,
   input  wire                         i_dest,
   input  wire [`MRX_DATA_W-1:0]       i_literal,
   // Return stack
   input  wire [`MRX_PC_W-1:0]         i_stack_top,
   output reg                          o_stack_pop,
   // Architectural state, pc load strobe and handshake
   output reg  [`MRX_DATA_W-1:0]       o_working,
   output reg                          o_zero,
   output reg  [`MRX_DATA_W-1:0]       o_irq_control,
   output reg  [`MRX_PC_W-1:0]         o_pc,
   output reg                          o_pc_load,
   output reg                          o_ready,
   output reg                          o_done
);

   ////////////////////////////////////////////////////////////////////////
   // Sequencer states
   // ST_RUN accepts one instruction per cycle; ST_RET2 is the flushed
   // second cycle of an interrupt return, during which nothing is taken.
   localparam ST_RUN  = 1'b0;
   localparam ST_RET2 = 1'b1;

   ////////////////////////////////////////////////////////////////////////
   // Storage and internal nets
   reg  [`MRX_DATA_W-1:0] file_mem [0:`MRX_FILE_DEPTH-1];
   reg                    state_ff;
   wire [`MRX_DATA_W-1:0] file_rd;
   wire [`MRX_DATA_W-1:0] alu_res;
   wire                   alu_zupd;
   wire                   take;
   wire                   dec_wr_file;
   wire                   dec_wr_work;
   wire                   dec_return;
   reg  [`MRX_DATA_W-1:0] nxt_working;
   reg                    nxt_zero;
   reg  [`MRX_DATA_W-1:0] nxt_irq_control;
   reg  [`MRX_PC_W-1:0]   nxt_pc;
   reg                    nxt_state;

   ////////////////////////////////////////////////////////////////////////
   // Decode helpers
   // Kept as functions so the write-enable and the working-register
   // paths decode the destination bit in exactly the same way.

   // Op carries a file operand and a destination bit
   function is_file_op;
      input [2:0] op;
      begin
         is_file_op = (op == `MRX_OP_OR_W_FILE) || (op == `MRX_OP_COPY_FILE);
      end
   endfunction

   // Op writes the addressed file register
   function writes_file;
      input [2:0] op;
      input       dest;
      begin
         writes_file = (op == `MRX_OP_STORE_W) || (is_file_op(op) && dest);
      end
   endfunction

   // Op writes the working register
   function writes_working;
      input [2:0] op;
      input       dest;
      begin
         writes_working = (op == `MRX_OP_LOAD_LIT) || (is_file_op(op) && !dest);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Acceptance and decoded strobes
   // Read is asynchronous, so a read of a word written this same cycle
   // sees the old value; the bench relies on that.
   assign file_rd     = file_mem[i_addr];
   assign take        = i_valid & o_ready;
   assign dec_wr_file = take & writes_file(i_op, i_dest);
   assign dec_wr_work = take & writes_working(i_op, i_dest);
   assign dec_return  = take & (i_op == `MRX_OP_IRQ_RETURN);

   ////////////////////////////////////////////////////////////////////////
   // Datapath helper
   mrx_alu mrx_alu_i (
      .i_op       (i_op),
      .i_w        (o_working),
      .i_file     (file_rd),
      .i_literal  (i_literal),
      .o_result   (alu_res),
      .o_zero_upd (alu_zupd)
   );

   ////////////////////////////////////////////////////////////////////////
   // File register writes; no reset so it maps to plain memory
   always @(posedge i_clock) begin
      if (i_reset_n && dec_wr_file) begin
         file_mem[i_addr] <= alu_res;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Next architectural state
   // Defaults hold every value, so idle and any unused op code change
   // nothing; flags move only for ops that the ALU marks.
   always @* begin
      nxt_working     = o_working;
      nxt_zero        = o_zero;
      nxt_irq_control = o_irq_control;
      nxt_pc          = o_pc;
      nxt_state       = state_ff;
      case (state_ff)
         ST_RUN: begin
            if (take && alu_zupd) begin
               nxt_zero = (alu_res == 8'h00);
            end
            if (dec_wr_work) begin
               nxt_working = alu_res;
            end
            if (dec_return) begin
               nxt_pc                         = i_stack_top;
               nxt_irq_control[`MRX_GIE_BIT]  = 1'b1;
               nxt_state                      = ST_RET2;
            end
         end
         ST_RET2: begin
            // Flushed slot: no state moves, just return to run
            nxt_state = ST_RUN;
         end
         default: begin
            nxt_state = ST_RUN;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Register stage
   // Return walk: take edge -> pc, pop, enable bit set and ready low;
   // next edge -> pc_load and done pulse, ready high again. Ready is
   // derived from the next state so it falls in the same edge that
   // enters the flushed slot and an offer in that slot is refused.
   always @(posedge i_clock) begin
      if (!i_reset_n) begin
         state_ff      <= ST_RUN;
         o_working     <= `MRX_W_RST;
         o_zero        <= 1'b0;
         o_irq_control <= `MRX_IRQ_CONTROL_REG_RST;
         o_pc          <= `MRX_PC_RST;
         o_pc_load     <= 1'b0;
         o_stack_pop   <= 1'b0;
         o_ready       <= 1'b1;
         o_done        <= 1'b0;
      end else begin
         state_ff      <= nxt_state;
         o_working     <= nxt_working;
         o_zero        <= nxt_zero;
         o_irq_control <= nxt_irq_control;
         o_pc          <= nxt_pc;
         // Pop and pc_load pulse for one cycle; done stays high across back-to-back completions
         o_stack_pop   <= dec_return;
         o_pc_load     <= (state_ff == ST_RET2);
         o_done        <= (take && !dec_return) || (state_ff == ST_RET2);
         o_ready       <= (nxt_state == ST_RUN);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Usage notes
   // The stack itself lives outside; this core only samples the top
   // value on the take edge and asks for one pop. A caller that also
   // pushes must not do so in the cycle of o_stack_pop.
   // The file array has no reset: software must write before reading.
   // Codes 6 and 7 on i_op behave as idle and complete in one cycle.

endmodule // mrx_core

// ==== rtl/mrx_defs.vh ====
/*
 Constants for the move / OR / return execution core.
 Assumes it is included by bare name from the rtl/ modules and the tb/ benches.
*/
// What this block does
// - OR working reg with file reg, set zero
// - Destination bit picks working or file reg
// - Copy-file always updates zero flag
// - Store working reg to file, flags unchanged
// - Load literal into working reg, flags unchanged
// - Interrupt return pops stack into program counter
// - Interrupt return sets global interrupt enable bit7
// - Interrupt return takes two instruction cycles
`ifndef MRX_DEFS_VH
`define MRX_DEFS_VH

// Operation select codes on i_op
`define MRX_OP_IDLE       3'h0
`define MRX_OP_OR_W_FILE  3'h1
`define MRX_OP_COPY_FILE  3'h2
`define MRX_OP_STORE_W    3'h3
`define MRX_OP_LOAD_LIT   3'h4
`define MRX_OP_IRQ_RETURN 3'h5

// Field positions and widths
`define MRX_ADDR_W        7
`define MRX_DATA_W        8
`define MRX_PC_W          13
`define MRX_GIE_BIT       7
`define MRX_FILE_DEPTH    128

// Reset values
`define MRX_W_RST         8'h00
`define MRX_IRQ_CONTROL_REG_RST    8'h00
`define MRX_PC_RST        13'h0000

// Cycle counts
`define MRX_RETURN_CYCLES 2

`endif

// ==== tb/move_or_return_insn_exec_bench.sv ====
/* Directed self-checking bench for mrx_core.
   Assumes rtl/ is on the include path. */
`timescale 1ns/1ps
`include "mrx_defs.vh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; \
   $display("ERROR %0t got %h want %h", $time, a, b); end end
module move_or_return_insn_exec_bench;
   logic        i_clock = 0, i_reset_n = 0, i_valid = 0, i_dest = 0;
   logic [2:0]  i_op = '0;
   logic [6:0]  i_addr = '0;
   logic [7:0]  i_literal = '0;
   logic [12:0] i_stack_top = '0;
   wire         o_stack_pop, o_zero, o_pc_load, o_ready, o_done;
   wire [7:0]   o_working, o_irq_control;
   wire [12:0]  o_pc;
   int          n_fail = 0, checks = 0, cyc = 0;
   mrx_core mrx_core_i (.*);
   always #4 i_clock = ~i_clock;
   // Hang guard, far above the few dozen cycles needed
   always @(posedge i_clock) if (++cyc == 2000) begin n_fail++; conclude(); end
   // One instruction offered; valid stays up for back-to-back issue
   task automatic go(input [2:0] op, input [6:0] a, input d, input [7:0] k);
      {i_op, i_addr, i_dest, i_literal, i_valid} = {op, a, d, k, 1'b1};
      @(posedge i_clock); #1;
   endtask
   task t_move;
      go(`MRX_OP_LOAD_LIT, 0, 0, 8'hA5); `CHK(o_working, 8'hA5)
      go(`MRX_OP_STORE_W, 7'h7F, 0, 0); `CHK(o_done, 1'b1)
      go(`MRX_OP_LOAD_LIT, 0, 0, 8'h00); go(`MRX_OP_COPY_FILE, 7'h7F, 0, 0);
      `CHK(o_working, 8'hA5)
      `CHK(o_zero, 1'b0)
      go(`MRX_OP_LOAD_LIT, 0, 0, 8'h00); go(`MRX_OP_STORE_W, 7'h00, 0, 0);
      go(`MRX_OP_LOAD_LIT, 0, 0, 8'h5A); go(`MRX_OP_COPY_FILE, 7'h00, 1, 0);
      `CHK(o_zero, 1'b1)
      `CHK(o_working, 8'h5A)
      $display("t_move done");
   endtask
   task t_or;
      go(`MRX_OP_LOAD_LIT, 0, 0, 8'h0F); go(`MRX_OP_STORE_W, 7'h10, 0, 0);
      go(`MRX_OP_LOAD_LIT, 0, 0, 8'h30); go(`MRX_OP_OR_W_FILE, 7'h10, 1, 0);
      `CHK(o_working, 8'h30)
      go(`MRX_OP_COPY_FILE, 7'h10, 0, 0); `CHK(o_working, 8'h3F)
      go(`MRX_OP_LOAD_LIT, 0, 0, 8'h00); go(`MRX_OP_OR_W_FILE, 7'h00, 0, 0);
      `CHK(o_zero, 1'b1)
      $display("t_or done");
   endtask
   task t_ret;
      i_stack_top = 13'h1ABC;
      go(`MRX_OP_IRQ_RETURN, 0, 0, 0); `CHK(o_pc, 13'h1ABC)
      `CHK({o_stack_pop, o_irq_control[7], o_ready}, 3'h6)
      go(`MRX_OP_LOAD_LIT, 0, 0, 8'h11); `CHK({o_pc_load, o_done}, 2'h3)
      go(`MRX_OP_IDLE, 0, 0, 0); `CHK(o_working, 8'h00)
      `CHK({o_done, o_pc}, {1'b1, 13'h1ABC})
      i_valid = 0;
      $display("t_ret done");
   endtask
   task conclude;
      $display("checks %0d failures %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge i_clock);
      #1 i_reset_n = 1;
      `CHK({o_ready, o_working}, 9'h100)
      t_move();
      t_or();
      t_ret();
      conclude();
   end
endmodule // move_or_return_insn_exec_bench

// ==== tb/mrx_core_sva.sv ====
/* Port checker for mrx_core.
   Assumes it is bound onto mrx_core. */
`timescale 1ns/1ps
`include "mrx_defs.vh"
module mrx_core_chk (
   input wire        i_clock, i_reset_n, i_valid, i_dest,
   input wire [2:0]  i_op,
   input wire [6:0]  i_addr,
   input wire [7:0]  i_literal, o_working, o_irq_control,
   input wire [12:0] i_stack_top, o_pc,
   input wire        o_stack_pop, o_zero, o_pc_load, o_ready, o_done
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_reset_n);
   // Taken instruction classes
   wire tk = i_valid && o_ready;
   wire rt = tk && i_op == `MRX_OP_IRQ_RETURN;
   wire fo = tk && (i_op == `MRX_OP_OR_W_FILE || i_op == `MRX_OP_COPY_FILE);
   property p_ret;
      rt |=> o_stack_pop && o_pc == $past(i_stack_top) && o_irq_control[7];
   endproperty
   a_ret: assert property (p_ret) else $error("return state wrong");
   property p_two; rt |=> !o_ready && !o_done ##1 o_pc_load && o_done && !o_stack_pop; endproperty
   a_two: assert property (p_two) else $error("return timing wrong");
   property p_rflag; rt |=> $stable(o_zero) [*2]; endproperty
   a_rflag: assert property (p_rflag) else $error("return moved zero");
   property p_load;
      tk && i_op == `MRX_OP_LOAD_LIT |=> o_working == $past(i_literal) && $stable(o_zero);
   endproperty
   a_load: assert property (p_load) else $error("load wrong");
   property p_store;
      tk && i_op == `MRX_OP_STORE_W |=> $stable(o_working) && $stable(o_zero);
   endproperty
   a_store: assert property (p_store) else $error("store moved state");
   property p_zero; fo && !i_dest |=> o_zero == (o_working == 8'h00); endproperty
   a_zero: assert property (p_zero) else $error("zero flag wrong");
   property p_dest; fo && i_dest |=> $stable(o_working); endproperty
   a_dest: assert property (p_dest) else $error("file dest wrote working");
   property p_one; tk && i_op < 3'h5 |=> o_done && o_ready; endproperty
   a_one: assert property (p_one) else $error("single cycle op late");
   property p_idle;
      tk && i_op == `MRX_OP_IDLE |=> $stable(o_working) && $stable(o_pc);
   endproperty
   a_idle: assert property (p_idle) else $error("idle changed state");
   c_ret: cover property (rt);
   c_zero: cover property (fo ##1 o_zero);
   c_refuse: cover property (i_valid && !o_ready);
endmodule // mrx_core_chk
bind mrx_core mrx_core_chk mrx_core_chk_i (.*);
